// ==== verilog/wave_engine.sv ====
// Programmable waveform engine: four waveform memories, data and
// trigger registers on the processor data bus, and the interval
// sequencer that drives the peripheral bus.
// Assumes one strobe cycle per processor access, synchronous pins,
// and first-word-fall-through FIFOs outside the block.
`timescale 1ns/10ps
module wave_engine
	import wave_engine_pkg::*;
(
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        reset_n,
	// Processor data bus
	input  wire logic [15:0] xaddr,
	input  wire logic [7:0]  xwdata,
	input  wire logic        xrd,
	input  wire logic        xwr,
	output logic      [7:0]  xrdata,
	// Peripheral bus
	input  wire logic [5:0]  rdy,
	input  wire logic [15:0] data_in,
	output logic      [15:0] data_out,
	output logic             data_oe,
	output logic      [5:0]  ctl_out,
	output logic      [5:0]  adr,
	// FIFO side
	input  wire logic        pf_flag,
	input  wire logic [1:0]  fifo_empty,
	input  wire logic [1:0]  fifo_full,
	input  wire logic [15:0] fifo_rd_data,
	output logic             fifo_sel,
	output logic             fifo_pop,
	output logic             fifo_push,
	output logic      [15:0] fifo_wr_data,
	// Events
	output logic             wave_irq,
	output logic             done_irq
);
	logic [1:0]  rst_sync;
	logic        rst_n;
	logic [7:0]  wave_mem [0:WAVE_ALL_BYTES-1];
	state_t      state;
	logic [1:0]  pgm;
	logic [2:0]  ip;
	logic [8:0]  cnt;
	logic        entering;
	logic        txn_write;
	logic        txn_fifo;
	logic        done;
	logic [7:0]  selector;
	logic        wide;
	logic        ready_bit;
	logic [15:0] rd_data;

	// Reset release
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			rst_sync <= 2'h0;
		else
			rst_sync <= {rst_sync[0], 1'b1};
	end
	assign rst_n = rst_sync[1];

	// Address decode
	wire sel_mem   = (xaddr >= WAVE_MEM_BASE_0)
		&& (xaddr < WAVE_MEM_END);
	wire sel_trig  = (xaddr == ADDR_LOW_TRIG);
	wire sel_fifoa = (xaddr == ADDR_FIFO_A);
	wire sel_fifob = (xaddr == ADDR_FIFO_B);
	wire is_idle   = (state == ST_IDLE);
	wire st_srd = is_idle && xrd && sel_trig;
	wire st_swr = is_idle && xwr && sel_trig;
	wire st_frd = is_idle && xrd && (sel_fifoa || sel_fifob);
	wire st_fwr = is_idle && xwr && (sel_fifoa || sel_fifob);
	wire start  = st_srd || st_swr || st_frd || st_fwr;
	wire start_write = st_swr || st_fwr;
	wire start_fifo  = st_frd || st_fwr;
	wire [1:0] start_pgm = st_swr ? selector[7:6] :
		st_srd ? selector[5:4] :
		st_fwr ? selector[3:2] : selector[1:0];

	desc_t desc;
	assign desc.len_branch = wave_mem[{pgm, FLD_LEN_BRANCH, ip}];
	assign desc.opcode     = wave_mem[{pgm, FLD_OPCODE, ip}];
	assign desc.out_ctl    = wave_mem[{pgm, FLD_OUTPUT, ip}];
	assign desc.logic_fn   = wave_mem[{pgm, FLD_LOGIC, ip}];

	wire is_dp    = desc.opcode[OP_DP];
	wire op_data  = desc.opcode[OP_DATA];
	wire op_next  = desc.opcode[OP_NEXT];
	wire op_incad = desc.opcode[OP_INCAD];
	wire op_interval_interrupt_request  = desc.opcode[OP_INTERVAL_INTERRUPT_REQUEST];

	wire [7:0] terms = {ready_bit, pf_flag, rdy};
	wire term_a = terms[desc.logic_fn[5:3]];
	wire term_b = terms[desc.logic_fn[2:0]];
	wire [1:0] fn = desc.logic_fn[7:6];
	wire result = (fn == FN_AND) ? (term_a & term_b) :
		(fn == FN_OR) ? (term_a | term_b) : (term_a ^ term_b);

	wire [8:0] len_cycles = (desc.len_branch == 8'h00) ?
		LEN_ZERO_CYCLES : {1'b0, desc.len_branch};
	wire [8:0] cur_left = entering ? len_cycles : cnt;
	wire       last = (cur_left == ONE_CYCLE);
	wire [8:0] next_cnt = cur_left - ONE_CYCLE;

	// Branch targets; self branch holds the interval
	wire [2:0] true_branch_target  = desc.len_branch[5:3];
	wire [2:0] false_branch_target = desc.len_branch[2:0];
	wire [2:0] next_ip = is_dp ?
		(result ? true_branch_target : false_branch_target) :
		(last ? ip + 3'h1 : ip);
	wire advance = is_dp || last;
	wire running = (state == ST_RUN);
	wire to_idle = running && (next_ip == IDX_IDLE);
	// More FIFO data left to move
	wire more = txn_write ? !fifo_empty[fifo_sel] :
		!fifo_full[fifo_sel];
	wire repeat_fifo = to_idle && txn_fifo && more;
	wire finish = to_idle && !repeat_fifo;
	wire sample = running && advance && op_data && !txn_write;

	always_ff @(posedge mclk)
	begin
		if (xwr && sel_mem)
			wave_mem[xaddr[6:0]] <= xwdata;
	end

	// Control registers
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			selector  <= SELECTOR_RESET;
			wide      <= 1'b0;
			ready_bit <= 1'b0;
		end
		else if (xwr && xaddr == ADDR_SELECTOR)
			selector  <= xwdata;
		else if (xwr && xaddr == ADDR_BUS_CFG)
			wide      <= xwdata[WIDE_BIT];
		else if (xwr && xaddr == ADDR_READY)
			ready_bit <= xwdata[READY_BIT];
	end

	// Read mux
	wire [7:0] high_rd = wide ? rd_data[15:8] : 8'h00;
	wire [7:0] rd_mux = sel_mem ? wave_mem[xaddr[6:0]] :
		(xaddr == ADDR_SELECTOR) ? selector :
		(xaddr == ADDR_BUS_CFG) ? {7'h00, wide} :
		(xaddr == ADDR_IDLE_STAT) ? {done, 7'h00} :
		(xaddr == ADDR_HIGH_DATA) ? high_rd :
		(xaddr == ADDR_LOW_QUIET) ? rd_data[7:0] :
		sel_trig ? rd_data[7:0] :
		(xaddr == ADDR_READY) ? {ready_bit, 7'h00} : 8'h00;

	// Trigger read returns the old captured data
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			xrdata <= 8'h00;
		else if (xrd)
			xrdata <= rd_mux;
	end

	// Write data; high byte first, trigger loads low
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			data_out <= 16'h0000;
		else if (running && entering && op_next && txn_fifo
			&& txn_write)
			data_out <= fifo_rd_data;
		else if (is_idle && xwr && xaddr == ADDR_HIGH_DATA)
			data_out[15:8] <= xwdata;
		else if (st_swr)
			data_out[7:0] <= xwdata;
	end

	// Captured read data
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			rd_data <= 16'h0000;
		else if (sample)
			rd_data <= data_in;
	end

	// Sequencer
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state     <= ST_IDLE;
			pgm       <= 2'h0;
			ip        <= IDX_FIRST;
			cnt       <= 9'h000;
			entering  <= 1'b0;
			txn_write <= 1'b0;
			txn_fifo  <= 1'b0;
			fifo_sel  <= 1'b0;
		end
		else
		begin
			case (state)
				ST_IDLE:
				begin
					if (start)
					begin
						state     <= ST_RUN;
						pgm       <= start_pgm;
						ip        <= IDX_FIRST;
						entering  <= 1'b1;
						txn_write <= start_write;
						txn_fifo  <= start_fifo;
						fifo_sel  <= sel_fifob;
					end
				end
				ST_RUN:
				begin
					cnt <= next_cnt;
					if (repeat_fifo)
					begin
						ip       <= IDX_FIRST;
						entering <= 1'b1;
					end
					else if (finish)
					begin
						state    <= ST_IDLE;
						ip       <= IDX_FIRST;
						entering <= 1'b0;
					end
					else
					begin
						ip       <= next_ip;
						entering <= advance && (next_ip != ip);
					end
				end
				default:
					state <= ST_IDLE;
			endcase
		end
	end

	// Done flag, set wins over the start clear
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			done <= 1'b1;
		else if (finish)
			done <= 1'b1;
		else if (start)
			done <= 1'b0;
	end

	// Pin and event outputs
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctl_out      <= CTL_IDLE;
			data_oe      <= 1'b0;
			adr          <= 6'h00;
			fifo_pop     <= 1'b0;
			fifo_push    <= 1'b0;
			fifo_wr_data <= 16'h0000;
			wave_irq     <= 1'b0;
			done_irq     <= 1'b0;
		end
		else
		begin
			// Pins idle together with the done pulse
			ctl_out  <= (running && !finish) ? desc.out_ctl[5:0]
				: CTL_IDLE;
			data_oe  <= running && !finish && txn_write && op_data;
			fifo_pop <= running && entering && op_next
				&& txn_fifo && txn_write;
			fifo_push <= sample && txn_fifo;
			done_irq <= finish;
			wave_irq <= running && entering && op_interval_interrupt_request;
			if (sample)
				fifo_wr_data <= data_in;
			if (running && entering && op_incad)
				adr <= adr + 6'h01;
		end
	end
endmodule // wave_engine

// ==== verilog/wave_engine_pkg.sv ====
// Constants, layouts and types of the programmable waveform engine.
// Assumes the processor data space is 16-bit addressed, 8-bit wide.
package wave_engine_pkg;
	// Waveform memory placement
	localparam logic [15:0] WAVE_MEM_BASE_0 = 16'h7900;
	localparam logic [15:0] WAVE_MEM_BASE_1 = 16'h7920;
	localparam logic [15:0] WAVE_MEM_BASE_2 = 16'h7940;
	localparam logic [15:0] WAVE_MEM_BASE_3 = 16'h7960;
	localparam logic [15:0] WAVE_MEM_END    = 16'h7980;
	localparam int          WAVE_MEM_BYTES  = 32;
	localparam int          WAVE_ALL_BYTES  = 128;
	// Field groups inside one memory
	localparam logic [1:0]  FLD_LEN_BRANCH  = 2'h0;
	localparam logic [1:0]  FLD_OPCODE      = 2'h1;
	localparam logic [1:0]  FLD_OUTPUT      = 2'h2;
	localparam logic [1:0]  FLD_LOGIC       = 2'h3;
	localparam logic [2:0]  IDX_IDLE        = 3'h7;
	localparam logic [2:0]  IDX_FIRST       = 3'h0;
	// Opcode bit positions
	localparam int          OP_DP           = 0;
	localparam int          OP_DATA         = 1;
	localparam int          OP_NEXT         = 2;
	localparam int          OP_INCAD        = 3;
	localparam int          OP_INTERVAL_INTERRUPT_REQUEST         = 4;
	// Combine function codes
	localparam logic [1:0]  FN_AND          = 2'h0;
	localparam logic [1:0]  FN_OR           = 2'h1;
	// Control and data registers
	localparam logic [15:0] ADDR_SELECTOR   = 16'h7824;
	localparam logic [15:0] ADDR_BUS_CFG    = 16'h78F0;
	localparam logic [15:0] ADDR_IDLE_STAT  = 16'h78F1;
	localparam logic [15:0] ADDR_HIGH_DATA  = 16'h78F2;
	localparam logic [15:0] ADDR_LOW_TRIG   = 16'h78F3;
	localparam logic [15:0] ADDR_LOW_QUIET  = 16'h78F4;
	localparam logic [15:0] ADDR_FIFO_A     = 16'h78F5;
	localparam logic [15:0] ADDR_FIFO_B     = 16'h78F6;
	localparam logic [15:0] ADDR_READY      = 16'h78F7;
	localparam logic [7:0]  SELECTOR_RESET  = 8'hE4;
	localparam int          DONE_BIT        = 7;
	localparam int          READY_BIT       = 7;
	localparam int          WIDE_BIT        = 0;
	localparam logic [5:0]  CTL_IDLE        = 6'h3F;
	localparam logic [8:0]  LEN_ZERO_CYCLES = 9'h100;
	localparam logic [8:0]  ONE_CYCLE       = 9'h001;

	typedef enum logic {
		ST_IDLE = 1'b0,
		ST_RUN  = 1'b1
	} state_t;

	typedef struct packed {
		logic [7:0] len_branch;
		logic [7:0] opcode;
		logic [7:0] out_ctl;
		logic [7:0] logic_fn;
	} desc_t;
endpackage

// ==== sim/wave_engine_monitor.sv ====
// Port checker of the waveform engine.
// Bound to wave_engine; sees its pins only.
`timescale 1ns/10ps
module wave_engine_monitor
	import wave_engine_pkg::*;
(
	// Clock, reset
	input wire logic        mclk,
	input wire logic        reset_n,
	// Processor bus
	input wire logic [15:0] xaddr,
	input wire logic        xrd,
	input wire logic [7:0]  xrdata,
	// Engine pins
	input wire logic        data_oe,
	input wire logic [5:0]  ctl_out,
	input wire logic [5:0]  adr,
	input wire logic        fifo_pop,
	input wire logic        fifo_push,
	input wire logic        wave_irq,
	input wire logic        done_irq
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);
	done_pulse_a: assert property (done_irq |=> !done_irq)
		else $error("done pulse long");
	wave_pulse_a: assert property (wave_irq |=> !wave_irq)
		else $error("wave pulse long");
	done_idle_a: assert property
		(done_irq |-> ctl_out == CTL_IDLE && !data_oe)
		else $error("busy at done");
	idle_hold_a: assert property
		(done_irq |=> (ctl_out == CTL_IDLE) [*2])
		else $error("idle lost");
	rdata_hold_a: assert property (!xrd |=> $stable(xrdata))
		else $error("read data moved");
	unmapped_zero_a: assert property
		(xrd && xaddr < ADDR_SELECTOR |=> xrdata == 8'h00)
		else $error("unmapped not zero");
	adr_step_a: assert property
		($changed(adr) |-> adr == $past(adr) + 6'h01)
		else $error("address jump");
	fifo_dir_a: assert property (!(fifo_pop && fifo_push))
		else $error("pop with push");
	cover property (done_irq);
	cover property (wave_irq);
	cover property (fifo_pop);
endmodule // wave_engine_monitor

// ==== sim/wave_peripheral.sv ====
// Peripheral model: slow ready, with read data in the same cycle.
// Read strobe is ctl_out bit 0 low.
`timescale 1ns/10ps
module wave_peripheral
(
	// Engine side
	input  wire logic        mclk,
	input  wire logic [5:0]  ctl_out,
	output logic      [5:0]  rdy = 6'h00,
	output logic      [15:0] data_in = 16'h0000,
	// Bench control
	input  wire logic [3:0]  wait_n,
	input  wire logic [15:0] value
);
	logic [3:0] count = 4'h0;
	wire        hit = !ctl_out[0] && count == wait_n;
	always @(posedge mclk)
	begin
		if (ctl_out[0])
			count <= 4'h0;
		else if (!hit)
			count <= count + 4'h1;
		rdy <= {~rdy[5:1], hit};
		data_in <= hit ? value : ~data_in;
	end
endmodule // wave_peripheral

// ==== sim/wave_engine_test.sv ====
// Bench of the waveform engine with a peripheral model.
// Assumes the package, engine and model are compiled first.
`timescale 1ns/10ps
module wave_engine_test
	import wave_engine_pkg::*;
;
	logic mclk = 1'b0, reset_n = 1'b0, xrd = 1'b0, xwr = 1'b0;
	logic [15:0] xaddr = 16'h0000, val = 16'h0000, lf = 16'h0EED;
	logic [7:0] xwdata = 8'h00, xrdata, v, lo, mem [0:127];
	logic [5:0] rdy, ctl_out, adr, am = 6'h00;
	logic [15:0] data_in, data_out, fifo_wr_data, fdat = 16'h0000;
	logic data_oe, fifo_sel, fifo_pop, fifo_push, wave_irq, done_irq;
	logic pf = 1'b0;
	logic [1:0] fe, ff;
	logic [15:0] dq = 16'h0000;
	logic [3:0] wn = 4'h2;
	logic [15:0] fq [$];
	int errors = 0, cmp_count = 0, cyc = 0, n, w, d, p, n0, w0, d0;
	int fcnt = 0, bcnt = 0;
	// Look-ahead flags count the pop or push still in flight
	assign fe = {1'b1, fcnt <= int'(fifo_pop)};
	assign ff = {bcnt + int'(fifo_push) >= 2, 1'b0};
	initial forever #2 mclk = ~mclk;
	wave_engine uut (.mclk(mclk), .reset_n(reset_n), .xaddr(xaddr),
		.xwdata(xwdata), .xrd(xrd), .xwr(xwr), .xrdata(xrdata), .rdy(rdy),
		.data_in(data_in), .data_out(data_out), .data_oe(data_oe),
		.ctl_out(ctl_out), .adr(adr), .pf_flag(pf), .fifo_empty(fe),
		.fifo_full(ff), .fifo_rd_data(fdat), .fifo_sel(fifo_sel),
		.fifo_pop(fifo_pop), .fifo_push(fifo_push),
		.fifo_wr_data(fifo_wr_data), .wave_irq(wave_irq),
		.done_irq(done_irq));
	wave_peripheral peer (.mclk(mclk), .ctl_out(ctl_out), .rdy(rdy),
		.data_in(data_in), .wait_n(wn), .value(val));
	function automatic logic [15:0] nx(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic chk(input string s, input logic [15:0] e, g);
		cmp_count++;
		if (g !== e)
		begin
			errors++;
			$display("wrong value %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] b);
		@(posedge mclk);
		xaddr <= a;
		xwdata <= b;
		xwr <= 1'b1;
		@(posedge mclk);
		xwr <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, output logic [7:0] b);
		@(posedge mclk);
		xaddr <= a;
		xrd <= 1'b1;
		@(posedge mclk);
		xrd <= 1'b0;
		#1 b = xrdata;
	endtask
	task automatic prog(input logic [15:0] b, input logic [2:0] i,
		input logic [7:0] lb, op, ov);
		wr(b + 16'(i), lb);
		wr(b + 16'(i) + 16'h0008, op);
		wr(b + 16'(i) + 16'h0010, ov);
		wr(b + 16'(i) + 16'h0018, 8'h00);
	endtask
	task automatic wd;
		for (int k = 0; k < 600 && d == d0; k++)
			@(posedge mclk);
		repeat (2) @(posedge mclk);
		chk("completions", 16'h0001, 16'(d - d0)); // one done
	endtask
	task automatic tally_and_finish;
		if (errors == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	always @(posedge mclk)
	begin
		cyc++;
		n += int'(data_oe);
		w += int'(wave_irq);
		d += int'(done_irq);
		p += int'(fifo_pop);
		if (fifo_pop && fq.size() > 0)
			void'(fq.pop_front());
		fcnt <= fq.size();
		bcnt <= bcnt + int'(fifo_push);
		if (fifo_push)
			chk("push data", dq, fifo_wr_data); // sampled word
		dq = data_in;
		fdat <= fq.size() > 0 ? fq[0] : ~fdat;
		pf <= lf[0];
		if (cyc == 20000)
		begin
			errors++;
			tally_and_finish();
		end
	end
	initial
	begin
		repeat (20) @(posedge mclk);
		reset_n <= 1'b1;
		repeat (3) @(posedge mclk);
		for (int i = 0; i < 128; i++)
		begin
			lf = nx(lf);
			mem[i] = lf[7:0];
			wr(WAVE_MEM_BASE_0 + 16'(i), lf[7:0]);
		end
		for (int i = 0; i < 128; i++)
		begin
			rd(WAVE_MEM_BASE_0 + 16'(i), v);
			chk("memory", 16'(mem[i]), 16'(v)); // bytes
		end
		rd(WAVE_MEM_END, v);
		chk("past end", 16'h0000, 16'(v)); // size limit
		rd(16'h0000, v);
		prog(WAVE_MEM_BASE_3, 3'h1, 8'h3F, 8'h01, 8'h15);
		for (int m = 0; m < 2; m++)
		begin
			prog(WAVE_MEM_BASE_3, 3'h0, 8'(1 - m), 8'h1A, 8'h15);
			lf = nx(lf);
			wr(ADDR_BUS_CFG, 8'(m));
			wr(ADDR_HIGH_DATA, lf[15:8]); // high first
			{n0, w0, d0} = {n, w, d};
			wr(ADDR_LOW_TRIG, lf[7:0]); // write start
			wr(ADDR_LOW_TRIG, ~lf[7:0]);
			wd();
			am = am + 6'h01;
			chk("oe cycles", m ? 16'd256 : 16'd1, 16'(n - n0)); // len
			chk("wave irq", 16'h0001, 16'(w - w0)); // interrupt
			chk("write low", 16'(lf[7:0]), 16'(data_out[7:0])); // data
			chk("write wide", lf, data_out); // wide word
			chk("address", 16'(am), 16'(adr)); // one step
		end
		prog(WAVE_MEM_BASE_2, 3'h0, 8'h08, 8'h03, 8'h0E); // wait
		prog(WAVE_MEM_BASE_2, 3'h1, 8'h3F, 8'h01, 8'h3F); // idle
		for (int m = 0; m < 2; m++)
		begin
			lf = nx(lf);
			val <= lf;
			wn <= lf[11:8];
			wr(ADDR_BUS_CFG, 8'(m));
			d0 = d;
			rd(ADDR_LOW_TRIG, v);
			if (m == 1)
				chk("trigger read", 16'(lo), 16'(v)); // old data
			wd();
			rd(ADDR_LOW_QUIET, v);
			chk("low data", 16'(lf[7:0]), 16'(v)); // low byte
			rd(ADDR_HIGH_DATA, v);
			chk("high data", m ? 16'(lf[15:8]) : 16'h0, 16'(v));
			rd(ADDR_IDLE_STAT, v);
			chk("done flag", 16'h0001, 16'(v[DONE_BIT])); // done
			lo = lf[7:0];
		end
		prog(WAVE_MEM_BASE_1, 3'h0, 8'h01, 8'h06, 8'h2B);
		prog(WAVE_MEM_BASE_1, 3'h1, 8'h3F, 8'h01, 8'h3F);
		for (int i = 0; i < 3; i++)
		begin
			lf = nx(lf);
			fq.push_back(lf);
		end
		repeat (2) @(posedge mclk);
		{n0, d0} = {p, d};
		wr(ADDR_FIFO_A, 8'h00); // FIFO write start
		wd();
		chk("pops", 16'd3, 16'(p - n0)); // drains FIFO
		chk("fifo word", lf, data_out); // last word
		prog(WAVE_MEM_BASE_0, 3'h0, 8'h01, 8'h02, 8'h3E);
		prog(WAVE_MEM_BASE_0, 3'h1, 8'h3F, 8'h01, 8'h3F);
		d0 = d;
		rd(ADDR_FIFO_B, v); // FIFO read start
		wd();
		chk("pushes", 16'd2, 16'(bcnt)); // fills FIFO
		chk("fifo select", 16'h0001, 16'(fifo_sel)); // B chosen
		tally_and_finish();
	end
endmodule // wave_engine_test
bind wave_engine wave_engine_monitor mon (.mclk(mclk), .reset_n(reset_n),
	.xaddr(xaddr), .xrd(xrd), .xrdata(xrdata), .data_oe(data_oe),
	.ctl_out(ctl_out), .adr(adr), .fifo_pop(fifo_pop),
	.fifo_push(fifo_push), .wave_irq(wave_irq), .done_irq(done_irq));
